// ### src/iiu_map.svh
// Constants of the internal interrupt unit: operation codes, register
// selects, source bit positions, source codes and reset values.
// Assumes inclusion by bare name from the unit's source files.
`ifndef IIU_MAP_SVH
`define IIU_MAP_SVH

// Register transfer operations issued by the microprogram.
`define IIU_OP_NONE   3'h0
`define IIU_OP_READ   3'h1
`define IIU_OP_WRITE  3'h2
`define IIU_OP_MSET   3'h3
`define IIU_OP_MCLR   3'h4

// Register selects.
`define IIU_SEL_CODE    3'h0
`define IIU_SEL_ENABLE  3'h1
`define IIU_SEL_LDET    3'h2
`define IIU_SEL_LEN     3'h3
`define IIU_SEL_PEA     3'h4
`define IIU_SEL_PES     3'h5
`define IIU_SEL_PGS     3'h6

// Source bit positions in the enable and detect registers.
`define IIU_BIT_MON    1
`define IIU_BIT_PROT   2
`define IIU_BIT_PGF    3
`define IIU_BIT_ILL    4
`define IIU_BIT_ERR    5
`define IIU_BIT_PRIV   6
`define IIU_BIT_IOX    7
`define IIU_BIT_PAR    8
`define IIU_BIT_MOR    9
`define IIU_BIT_POW    10

// Source codes reported in the code register (octal 10, 11, 12 for bits 8-10).
`define IIU_CODE_NONE  4'h0
`define IIU_CODE_POW   4'ha

// Level served by the internal sources.
`define IIU_LEVEL_INT  4'he
`define IIU_LEVEL_BIT  14

// Level detect bits that external sources may set: 15, 13, 12, 11, 10.
`define IIU_LDET_EXT_MASK  16'hbc00

// Reset values.
`define IIU_RST_ENABLE  11'h000
`define IIU_RST_WORD    16'h0000
`define IIU_RST_CODE    4'h0

`endif

// ### src/iiu_pkg.sv
// Types shared by the internal interrupt unit modules.
// Assumes nothing of its surroundings.
package iiu_pkg;
   typedef logic [15:0] iiu_word_t;
   typedef logic [10:0] iiu_src_t;
   typedef logic [3:0]  iiu_code_t;
endpackage

// ### src/iiu_cap_if.sv
// Carrier between the unit's top and one lockable capture register.
// Assumes a single clock domain.
`timescale 1ns/1ns
`default_nettype none
interface iiu_cap_if #(parameter int W = 16);
   logic         capture;
   logic         unlock;
   logic [W-1:0] din;
   logic [W-1:0] dout;
   logic         locked;
   modport owner (output capture, output unlock, output din, input dout, input locked);
   modport store (input capture, input unlock, input din, output dout, output locked);
endinterface
`default_nettype wire

// ### src/iiu_capture.sv
// Lockable capture register: takes one value and then holds it until
// software reads it and so unlocks it.
// Assumes the owner pulses unlock on the read and capture on the event.
`timescale 1ns/1ns
`default_nettype none
module iiu_capture
   import iiu_pkg::*;
#(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic     i_clk,
   input wire logic     i_rst,
   // Owner side
   iiu_cap_if.store     cap
);
   logic [W-1:0] value;
   logic         locked;
   logic [W-1:0] next_value;
   logic         next_locked;

   // A capture in the unlocking cycle is kept, so no event is lost.
   always_comb begin
      next_value  = value;
      next_locked = locked;
      if (cap.unlock) begin
         next_locked = 1'b0;
      end
      if (cap.capture && (!locked || cap.unlock)) begin
         next_value  = cap.din;
         next_locked = 1'b1;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         value  <= '0;
         locked <= 1'b0;
      end else begin
         value  <= next_value;
         locked <= next_locked;
      end
   end

   assign cap.dout   = value;
   assign cap.locked = locked;
endmodule
`default_nettype wire

// ### src/iiu_top.sv
// Internal interrupt unit: latches internal trap and error sources, gates them
// by the source enable register, reports a code and requests level 14; also
// holds the level detect and level enable registers and their priority encoder.
// Assumes a microprogram issuing one register transfer per cycle and source
// inputs that are one-cycle pulses, except the error flag and power sense.
// Function
// - Any enabled internal condition requests priority level 14.
// - Code register holds 0 to octal 12 naming the interrupting source.
// - Eleven-bit enable register, written from accumulator, gates each source.
// - Enable bits: 1 monitor, 2 protect, 3 page, 4 illegal, 5 error...
// - Code equals bit number; bits 8, 9, 10 give octal 10, 11, 12.
// - Monitor call loads level 14 temporary with sign-extended eight-bit code.
// - Monitor call with prefetch page fault loads temporary but reports page fault.
// - Protect or ring violation raises protect source; details into paging status.
// - Nonresident page reference raises page fault; details into paging status.
// - Unimplemented opcode raises illegal instruction source.
// - Set error flag raises the error indicator source.
// - Error source raises again on each re-entry of the flagged level.
// - Attempted privileged instruction raises privileged instruction source.
// - Missing data-ready answer raises the I/O error source.
// - Parity error captures low address and status in parity registers.
// - Nonexistent memory raises out-of-range and captures low address.
// - Power fail takes precedence over simultaneous internal sources.
// - Code read places code in bits 0-3, zeros above.
// - Reading the code register clears it.
// - Code and paging status registers lock until read; read unlocks.
// - Level detect and enable readable; transfer write copies accumulator.
// - Masked set writes ones where accumulator bits are one.
// - Masked clear writes zeros where accumulator bits are one.
// - Internal sources drive level detect bit 14; external drive bits 15, 13, 12, 11, 10.
// - Highest level set in detect and enable interrupts if above current and on.
`timescale 1ns/1ns
`default_nettype none
`include "iiu_map.svh"
module iiu_top
   import iiu_pkg::*;
(
   // Clock and reset
   input  wire logic        I_CLK_SYS,
   input  wire logic        I_RST,
   // Register transfer port
   input  wire logic [2:0]  I_OP,
   input  wire logic [2:0]  I_SEL,
   input  wire logic [15:0] I_ACC,
   output logic [15:0]      O_RDATA,
   // Internal sources
   input  wire logic        I_MON_CALL,
   input  wire logic [7:0]  I_MON_CODE,
   input  wire logic        I_PREFETCH_FAULT,
   input  wire logic        I_PROT_VIOL,
   input  wire logic        I_PAGE_FAULT,
   input  wire logic [15:0] I_PAGING_INFO,
   input  wire logic        I_ILLEGAL_OP,
   input  wire logic        I_ERROR_FLAG,
   input  wire logic        I_PRIV_OP,
   input  wire logic        I_IO_NO_READY,
   input  wire logic        I_PARITY_ERR,
   input  wire logic        I_OUT_OF_RANGE,
   input  wire logic [15:0] I_MEM_ADDR,
   input  wire logic [15:0] I_MEM_STATUS,
   input  wire logic        I_POWER_SENSE,
   // External level sources and processor state
   input  wire logic [15:0] I_EXT_SET,
   input  wire logic [3:0]  I_CUR_LEVEL,
   input  wire logic        I_INT_ON,
   // Outputs to the processor
   output logic             O_LEVEL14_REQ,
   output logic             O_INTERRUPT,
   output logic [3:0]       O_NEW_LEVEL,
   output logic             O_T14_LOAD,
   output logic [15:0]      O_T14_DATA
);
   iiu_src_t  enable;
   iiu_src_t  detect;
   iiu_code_t code;
   logic      code_locked;
   iiu_word_t ldet;
   iiu_word_t len;
   logic [3:0] prev_level;
   logic       prev_err;
   logic       prev_pow;
   iiu_word_t  rdata;
   logic       t14_load;
   iiu_word_t  t14_data;

   iiu_src_t  next_enable;
   iiu_src_t  next_detect;
   iiu_code_t next_code;
   logic      next_code_locked;
   iiu_word_t next_ldet;
   iiu_word_t next_len;
   iiu_word_t next_rdata;
   logic      next_t14_load;
   iiu_word_t next_t14_data;

   iiu_src_t  events;
   iiu_src_t  pending;
   iiu_code_t top_code;
   logic      any_pending;
   logic      rd;
   logic      rd_code;
   logic      err_event;
   iiu_word_t masked;
   logic [3:0] top_level;
   logic       top_valid;

   iiu_cap_if #(.W(16)) pea_if ();
   iiu_cap_if #(.W(16)) pes_if ();
   iiu_cap_if #(.W(16)) pgs_if ();

   iiu_capture #(.W(16)) u_pea (
      .i_clk (I_CLK_SYS),
      .i_rst (I_RST),
      .cap   (pea_if.store)
   );
   iiu_capture #(.W(16)) u_pes (
      .i_clk (I_CLK_SYS),
      .i_rst (I_RST),
      .cap   (pes_if.store)
   );
   iiu_capture #(.W(16)) u_pgs (
      .i_clk (I_CLK_SYS),
      .i_rst (I_RST),
      .cap   (pgs_if.store)
   );

   assign rd      = (I_OP == `IIU_OP_READ);
   assign rd_code = rd && (I_SEL == `IIU_SEL_CODE);

   // The error flag is a per-level level signal; re-arm on every level change.
   assign err_event = I_ERROR_FLAG && (!prev_err || (I_CUR_LEVEL != prev_level));

   always_comb begin
      events = '0;
      events[`IIU_BIT_MON]  = I_MON_CALL && !I_PREFETCH_FAULT;
      events[`IIU_BIT_PROT] = I_PROT_VIOL;
      events[`IIU_BIT_PGF]  = I_PAGE_FAULT || (I_MON_CALL && I_PREFETCH_FAULT);
      events[`IIU_BIT_ILL]  = I_ILLEGAL_OP;
      events[`IIU_BIT_ERR]  = err_event;
      events[`IIU_BIT_PRIV] = I_PRIV_OP;
      events[`IIU_BIT_IOX]  = I_IO_NO_READY;
      events[`IIU_BIT_PAR]  = I_PARITY_ERR;
      events[`IIU_BIT_MOR]  = I_OUT_OF_RANGE;
      events[`IIU_BIT_POW]  = I_POWER_SENSE && !prev_pow;
   end

   assign pending     = detect & enable;
   assign any_pending = |pending;

   // Highest bit wins, so power fail (bit 10) always beats the rest.
   always_comb begin
      top_code = `IIU_CODE_NONE;
      for (int i = 0; i < 11; i++) begin
         if (pending[i]) begin
            top_code = 4'(i);
         end
      end
   end

   // Capture registers: parity address and status, paging status.
   assign pea_if.capture = I_PARITY_ERR || I_OUT_OF_RANGE;
   assign pea_if.din     = I_MEM_ADDR;
   assign pes_if.capture = I_PARITY_ERR || I_OUT_OF_RANGE;
   assign pes_if.din     = I_MEM_STATUS;
   // A prefetch fault behind a monitor call is a page fault and records it too.
   assign pgs_if.capture = I_PROT_VIOL || events[`IIU_BIT_PGF];
   assign pgs_if.din     = I_PAGING_INFO;
   // A read of the parity status unlocks both parity registers together.
   assign pea_if.unlock  = rd && (I_SEL == `IIU_SEL_PES);
   assign pes_if.unlock  = rd && (I_SEL == `IIU_SEL_PES);
   assign pgs_if.unlock  = rd && (I_SEL == `IIU_SEL_PGS);

   // Source detect, code register and enable register.
   always_comb begin
      next_detect      = detect;
      next_code        = code;
      next_code_locked = code_locked;
      next_enable      = enable;
      if (I_OP == `IIU_OP_WRITE && I_SEL == `IIU_SEL_ENABLE) begin
         next_enable = I_ACC[10:0];
      end
      if (rd_code) begin
         next_code        = `IIU_CODE_NONE;
         next_code_locked = 1'b0;
      end
      // A locked code waits for its read; the source stays latched meanwhile.
      if (!code_locked && any_pending) begin
         next_code        = top_code;
         next_code_locked = 1'b1;
         next_detect[top_code] = 1'b0;
      end
      next_detect = next_detect | events;
   end

   // Level detect and level enable registers with transfer, set and clear.
   always_comb begin
      next_ldet = ldet;
      next_len  = len;
      case (I_OP)
         `IIU_OP_WRITE: begin
            if (I_SEL == `IIU_SEL_LDET) next_ldet = I_ACC;
            if (I_SEL == `IIU_SEL_LEN)  next_len  = I_ACC;
         end
         `IIU_OP_MSET: begin
            if (I_SEL == `IIU_SEL_LDET) next_ldet = ldet | I_ACC;
            if (I_SEL == `IIU_SEL_LEN)  next_len  = len | I_ACC;
         end
         `IIU_OP_MCLR: begin
            if (I_SEL == `IIU_SEL_LDET) next_ldet = ldet & ~I_ACC;
            if (I_SEL == `IIU_SEL_LEN)  next_len  = len & ~I_ACC;
         end
         default: begin
         end
      endcase
      // Hardware sets win over a software clear in the same cycle.
      next_ldet = next_ldet | (I_EXT_SET & `IIU_LDET_EXT_MASK);
      if (any_pending) begin
         next_ldet[`IIU_LEVEL_BIT] = 1'b1;
      end
   end

   // Read data, registered one cycle after the read.
   always_comb begin
      next_rdata = rdata;
      if (rd) begin
         case (I_SEL)
            `IIU_SEL_CODE: next_rdata = {12'h000, code};
            `IIU_SEL_LDET: next_rdata = ldet;
            `IIU_SEL_LEN:  next_rdata = len;
            `IIU_SEL_PEA:  next_rdata = pea_if.dout;
            `IIU_SEL_PES:  next_rdata = pes_if.dout;
            `IIU_SEL_PGS:  next_rdata = pgs_if.dout;
            default:       next_rdata = `IIU_RST_WORD;
         endcase
      end
   end

   // Monitor call code into the level 14 temporary register, even on a fault.
   always_comb begin
      next_t14_load = I_MON_CALL;
      next_t14_data = t14_data;
      if (I_MON_CALL) begin
         next_t14_data = {{8{I_MON_CODE[7]}}, I_MON_CODE};
      end
   end

   // Priority encoder over the level registers.
   assign masked = ldet & len;
   always_comb begin
      top_level = 4'h0;
      top_valid = 1'b0;
      for (int i = 0; i < 16; i++) begin
         if (masked[i]) begin
            top_level = 4'(i);
            top_valid = 1'b1;
         end
      end
   end

   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         enable      <= `IIU_RST_ENABLE;
         detect      <= '0;
         code        <= `IIU_RST_CODE;
         code_locked <= 1'b0;
         ldet        <= `IIU_RST_WORD;
         len         <= `IIU_RST_WORD;
         prev_level  <= 4'h0;
         prev_err    <= 1'b0;
         prev_pow    <= 1'b0;
         rdata       <= `IIU_RST_WORD;
         t14_load    <= 1'b0;
         t14_data    <= `IIU_RST_WORD;
      end else begin
         enable      <= next_enable;
         detect      <= next_detect;
         code        <= next_code;
         code_locked <= next_code_locked;
         ldet        <= next_ldet;
         len         <= next_len;
         prev_level  <= I_CUR_LEVEL;
         prev_err    <= I_ERROR_FLAG;
         prev_pow    <= I_POWER_SENSE;
         rdata       <= next_rdata;
         t14_load    <= next_t14_load;
         t14_data    <= next_t14_data;
      end
   end

   assign O_RDATA       = rdata;
   assign O_LEVEL14_REQ = ldet[`IIU_LEVEL_BIT] && len[`IIU_LEVEL_BIT];
   assign O_NEW_LEVEL   = top_level;
   assign O_INTERRUPT   = top_valid && I_INT_ON && (top_level > I_CUR_LEVEL);
   assign O_T14_LOAD    = t14_load;
   assign O_T14_DATA    = t14_data;
endmodule
`default_nettype wire

// ### tb/iiu_top_chk.sv
// Checker for the internal interrupt unit top, watching its ports only.
// Assumes the single processor clock and the register transfer codes of the map.
`timescale 1ns/1ns
`default_nettype none
`include "iiu_map.svh"
module iiu_top_chk (
   input wire logic        I_CLK_SYS,
   input wire logic        I_RST,
   input wire logic [2:0]  I_OP,
   input wire logic [2:0]  I_SEL,
   input wire logic [15:0] I_ACC,
   input wire logic [15:0] O_RDATA,
   input wire logic        I_MON_CALL,
   input wire logic [7:0]  I_MON_CODE,
   input wire logic [3:0]  I_CUR_LEVEL,
   input wire logic        I_INT_ON,
   input wire logic        O_LEVEL14_REQ,
   input wire logic        O_INTERRUPT,
   input wire logic [3:0]  O_NEW_LEVEL,
   input wire logic        O_T14_LOAD,
   input wire logic [15:0] O_T14_DATA
);
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (I_RST);
   sequence len_op(logic [2:0] op);
      (I_OP == op && I_SEL == `IIU_SEL_LEN) ##1 (I_OP == `IIU_OP_NONE)
         ##1 (I_OP == `IIU_OP_READ && I_SEL == `IIU_SEL_LEN);
   endsequence
   chk_req_level: assert property (O_LEVEL14_REQ |-> O_NEW_LEVEL >= 4'he)
      else $error("level 14 request without level 14 selected");
   chk_int_above: assert property (O_INTERRUPT |-> I_INT_ON && O_NEW_LEVEL > I_CUR_LEVEL)
      else $error("interrupt without a higher level or with system off");
   chk_code_read: assert property ((I_OP == `IIU_OP_READ && I_SEL == `IIU_SEL_CODE)
      |=> O_RDATA[15:4] == 12'h000 && O_RDATA[3:0] <= 4'ha)
      else $error("code read out of range");
   chk_t14_load: assert property (I_MON_CALL |=> O_T14_LOAD
      && O_T14_DATA[7:0] == $past(I_MON_CODE) && O_T14_DATA[15:8] == {8{O_T14_DATA[7]}})
      else $error("monitor code not loaded sign extended");
   chk_t14_quiet: assert property (!I_MON_CALL |=> !O_T14_LOAD)
      else $error("temporary load without monitor call");
   chk_len_set: assert property (len_op(`IIU_OP_MSET)
      |=> (O_RDATA & $past(I_ACC, 3)) == $past(I_ACC, 3))
      else $error("masked set left a bit clear");
   chk_len_clear: assert property (len_op(`IIU_OP_MCLR) |=> (O_RDATA & $past(I_ACC, 3)) == 16'h0000)
      else $error("masked clear left a bit set");
   chk_len_copy: assert property (len_op(`IIU_OP_WRITE) |=> O_RDATA == $past(I_ACC, 3))
      else $error("transfer write not copied");
   chk_rdata_hold: assert property (I_OP != `IIU_OP_READ |=> $stable(O_RDATA))
      else $error("read data changed without a read");
   cov_mon: cover property (I_MON_CALL ##1 O_T14_LOAD);
   cov_int: cover property (O_INTERRUPT);
   cov_req: cover property (O_LEVEL14_REQ ##[1:4] I_OP == `IIU_OP_READ);
endmodule
bind iiu_top iiu_top_chk i_iiu_top_chk (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_OP(I_OP),
   .I_SEL(I_SEL), .I_ACC(I_ACC), .O_RDATA(O_RDATA), .I_MON_CALL(I_MON_CALL),
   .I_MON_CODE(I_MON_CODE), .I_CUR_LEVEL(I_CUR_LEVEL), .I_INT_ON(I_INT_ON),
   .O_LEVEL14_REQ(O_LEVEL14_REQ), .O_INTERRUPT(O_INTERRUPT), .O_NEW_LEVEL(O_NEW_LEVEL),
   .O_T14_LOAD(O_T14_LOAD), .O_T14_DATA(O_T14_DATA));
`default_nettype wire

// ### tb/iiu_core_model.sv
// Microprogram side: issues one register transfer and collects the answer.
// Assumes the unit answers a read on the edge that takes the request.
`timescale 1ns/1ns
`default_nettype none
`include "iiu_map.svh"
module iiu_core_model (
   // Clock and answer
   input  wire logic        i_clk,
   input  wire logic [15:0] i_rdata,
   // Request
   output logic [2:0]       o_op,
   output logic [2:0]       o_sel,
   output logic [15:0]      o_acc
);
   initial begin
      o_op  = `IIU_OP_NONE;
      o_sel = 3'h0;
      o_acc = 16'h0000;
   end
   // The request stands over exactly one rising edge, then the bus idles.
   task automatic xfer(input logic [2:0] op, input logic [2:0] sel, input logic [15:0] acc,
                       output logic [15:0] data);
      @(negedge i_clk);
      o_op  = op;
      o_sel = sel;
      o_acc = acc;
      @(negedge i_clk);
      data  = i_rdata;
      o_op  = `IIU_OP_NONE;
      o_acc = ~acc;
   endtask
endmodule
`default_nettype wire

// ### tb/iiu_top_tb_top.sv
// Self-checking bench for the internal interrupt unit top.
// Assumes the core model for register transfers and pulsed sources.
`timescale 1ns/1ns
`default_nettype none
`include "iiu_map.svh"
module iiu_top_tb_top;
   import iiu_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [10:0] src = 11'h000;
   logic        pf = 1'b0, int_on = 1'b0;
   logic [3:0]  cur = 4'h0;
   logic [7:0]  mon_code = 8'h85;
   logic [15:0] addr = 16'hbeef, rdata, t14, d;
   logic [15:0] ext = 16'h0000, pinfo = 16'h1234;
   logic [2:0]  op, sel;
   logic        req, intr, t14_ld;
   logic [3:0]  new_lvl;
   iiu_word_t   acc;
   int          failures = 0, cmp_count = 0, cyc = 0;
   initial forever #10 clk = ~clk;
   iiu_core_model i_iiu_core_model (.i_clk(clk), .i_rdata(rdata), .o_op(op), .o_sel(sel),
      .o_acc(acc));
   iiu_top i_iiu_top (.I_CLK_SYS(clk), .I_RST(rst), .I_OP(op), .I_SEL(sel), .I_ACC(acc),
      .O_RDATA(rdata), .I_MON_CALL(src[1]), .I_MON_CODE(mon_code), .I_PREFETCH_FAULT(pf),
      .I_PROT_VIOL(src[2]), .I_PAGE_FAULT(src[3]), .I_PAGING_INFO(pinfo),
      .I_ILLEGAL_OP(src[4]), .I_ERROR_FLAG(src[5]), .I_PRIV_OP(src[6]),
      .I_IO_NO_READY(src[7]), .I_PARITY_ERR(src[8]), .I_OUT_OF_RANGE(src[9]),
      .I_MEM_ADDR(addr), .I_MEM_STATUS(16'h0042), .I_POWER_SENSE(src[10]),
      .I_EXT_SET(ext), .I_CUR_LEVEL(cur), .I_INT_ON(int_on), .O_LEVEL14_REQ(req),
      .O_INTERRUPT(intr), .O_NEW_LEVEL(new_lvl), .O_T14_LOAD(t14_ld), .O_T14_DATA(t14));
   task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic xf(input logic [2:0] o, input logic [2:0] s, input logic [15:0] a);
      i_iiu_core_model.xfer(o, s, a, d);
   endtask
   // Sources are held for one cycle, then two more let the code settle.
   task automatic pulse(input logic [10:0] m);
      @(negedge clk);
      src = m;
      @(negedge clk);
      src = 11'h000;
      pf  = 1'b0;
      repeat (2) @(negedge clk);
   endtask
   task automatic code_is(input logic [15:0] e);
      xf(`IIU_OP_READ, `IIU_SEL_CODE, 16'h0);
      check("code", e, d);
   endtask
   task automatic t_prio;
      pulse(11'h500);
      check("request", 16'h1, {15'h0, req});
      code_is(16'h000a);
      code_is(16'h0008);
      xf(`IIU_OP_READ, `IIU_SEL_PEA, 16'h0);
      check("parity address", 16'hbeef, d);
      xf(`IIU_OP_MCLR, `IIU_SEL_LDET, 16'h4000);
   endtask
   task automatic t_codes;
      for (int i = 1; i <= 10; i++) begin
         pulse(11'h001 << i);
         check("request", 16'h1, {15'h0, req});
         code_is(16'(i));
         code_is(16'h0000);
         xf(`IIU_OP_MCLR, `IIU_SEL_LDET, 16'h4000);
      end
   endtask
   task automatic t_disabled;
      xf(`IIU_OP_WRITE, `IIU_SEL_ENABLE, 16'h07ee);
      pulse(11'h010);
      check("masked request", 16'h0, {15'h0, req});
      xf(`IIU_OP_WRITE, `IIU_SEL_ENABLE, 16'h07fe);
      repeat (2) @(negedge clk);
      check("late request", 16'h1, {15'h0, req});
      code_is(16'h0004);
      xf(`IIU_OP_MCLR, `IIU_SEL_LDET, 16'h4000);
   endtask
   task automatic t_mon_pf;
      pf = 1'b1;
      mon_code = 8'h7a;
      pulse(11'h002);
      check("temporary", 16'h007a, t14);
      code_is(16'h0003);
      code_is(16'h0000);
      xf(`IIU_OP_MCLR, `IIU_SEL_LDET, 16'h4000);
   endtask
   task automatic t_capture;
      pinfo = 16'h5678;
      xf(`IIU_OP_READ, `IIU_SEL_PES, 16'h0);
      check("parity status", 16'h0042, d);
      addr = 16'h0123;
      pulse(11'h200);
      code_is(16'h0009);
      xf(`IIU_OP_READ, `IIU_SEL_PEA, 16'h0);
      check("range address", 16'h0123, d);
      addr = 16'h4567;
      pulse(11'h200);
      code_is(16'h0009);
      xf(`IIU_OP_READ, `IIU_SEL_PEA, 16'h0);
      check("locked address", 16'h0123, d);
      xf(`IIU_OP_READ, `IIU_SEL_PGS, 16'h0);
      check("paging status", 16'h1234, d);
      pulse(11'h008);
      code_is(16'h0003);
      xf(`IIU_OP_READ, `IIU_SEL_PGS, 16'h0);
      check("new paging status", 16'h5678, d);
      xf(`IIU_OP_MCLR, `IIU_SEL_LDET, 16'h4000);
   endtask
   // The error flag is held high; only a level change may raise it again.
   task automatic t_err;
      @(negedge clk);
      src = 11'h020;
      repeat (3) @(negedge clk);
      code_is(16'h0005);
      code_is(16'h0000);
      cur = 4'h2;
      repeat (3) @(negedge clk);
      code_is(16'h0005);
      src = 11'h000;
      cur = 4'h0;
      xf(`IIU_OP_MCLR, `IIU_SEL_LDET, 16'h4000);
   endtask
   task automatic t_levels;
      xf(`IIU_OP_WRITE, `IIU_SEL_LEN, 16'h3c00);
      xf(`IIU_OP_READ, `IIU_SEL_LEN, 16'h0);
      check("enable copy", 16'h3c00, d);
      xf(`IIU_OP_MSET, `IIU_SEL_LEN, 16'h8001);
      xf(`IIU_OP_READ, `IIU_SEL_LEN, 16'h0);
      check("enable set", 16'hbc01, d);
      xf(`IIU_OP_MCLR, `IIU_SEL_LEN, 16'h0c01);
      xf(`IIU_OP_READ, `IIU_SEL_LEN, 16'h0);
      check("enable clear", 16'hb000, d);
      xf(`IIU_OP_WRITE, `IIU_SEL_LDET, 16'h9000);
      xf(`IIU_OP_READ, `IIU_SEL_LDET, 16'h0);
      check("detect copy", 16'h9000, d);
      ext = 16'h4c01;
      @(negedge clk);
      ext = 16'h0000;
      xf(`IIU_OP_READ, `IIU_SEL_LDET, 16'h0);
      check("external set", 16'h9c00, d);
      int_on = 1'b1;
      cur = 4'h3;
      @(negedge clk);
      check("new level", 16'h000f, {12'h0, new_lvl});
      check("interrupt", 16'h1, {15'h0, intr});
      cur = 4'hf;
      @(negedge clk);
      check("no interrupt", 16'h0, {15'h0, intr});
      cur = 4'h3;
      int_on = 1'b0;
      @(negedge clk);
      check("system off", 16'h0, {15'h0, intr});
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         failures++;
         stop_test;
      end
   end
   initial begin
      repeat (4) @(negedge clk);
      rst = 1'b0;
      code_is(16'h0000);
      xf(`IIU_OP_WRITE, `IIU_SEL_ENABLE, 16'h07fe);
      xf(`IIU_OP_WRITE, `IIU_SEL_LEN, 16'h4000);
      t_prio;
      t_codes;
      t_disabled;
      t_mon_pf;
      t_capture;
      t_err;
      t_levels;
      stop_test;
   end
endmodule
`default_nettype wire
